// ==== design/oscsrc_pkg.sv ====
// package: register map, field layout, reset values and types of the oscillator source control
package oscsrc_pkg;
  // register byte offsets
  localparam logic [7:0] EXT_OSC_CONTROL_OFS = 8'h00;
  localparam logic [7:0] CLOCK_SELECT_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  // ext_osc_control_reg fields
  localparam int FREQ_RANGE_LSB = 0;
  localparam int MODE_LSB = 4;
  localparam int VALID_FLAG_BIT = 7;
  localparam int PERIPH_ROUTE_BIT = 8;
  // system_clock_select fields
  localparam int SELECT_LSB = 0;
  // status fields
  localparam int ACTIVE_SRC_LSB = 0;
  localparam int SWITCH_BUSY_BIT = 4;
  localparam int LP_OSC_ON_BIT = 5;
  // reset values
  localparam logic [2:0] FREQ_RANGE_RST = 3'h0;
  localparam logic [2:0] SELECT_RST = 3'h4;
  // stable edges the valid detector needs before reporting a running source
  localparam int VALID_EDGES = 16;

  typedef enum logic [2:0] {
    OSCSRC_MODE_OFF = 3'b000,
    OSCSRC_MODE_CMOS = 3'b010,
    OSCSRC_MODE_CMOS_DIV2 = 3'b011,
    OSCSRC_MODE_RC = 3'b100,
    OSCSRC_MODE_CAP = 3'b101,
    OSCSRC_MODE_XTAL = 3'b110,
    OSCSRC_MODE_XTAL_DIV2 = 3'b111
  } oscsrc_mode_e;

  // decoded source of the undivided system clock
  typedef enum logic [1:0] {
    OSCSRC_SRC_PREC = 2'b00,
    OSCSRC_SRC_EXT = 2'b01,
    OSCSRC_SRC_RSVD = 2'b10,
    OSCSRC_SRC_RTC = 2'b11
  } oscsrc_src_e;

  typedef struct packed {
    logic [2:0] freq_range;
    logic [2:0] mode;
    logic periph_route;
  } oscsrc_cfg_s;

  typedef struct packed {
    logic lp_osc_enable;
    logic ext_osc_enable;
    logic pin_one_analog;
    logic pin_two_analog;
    logic pin_two_digital_in;
  } oscsrc_pwr_s;
endpackage

// ==== design/oscsrc_ctrl.sv ====
// oscillator source control: low-power oscillator gating, external drive and clock select
//
// Contract
// (RULE_01) reset selects the low-power internal oscillator as system clock.
// (RULE_02) low-power oscillator runs only while it is the selected source; the code keeps it on while select or active is 1xx.
// (RULE_03) external clock goes to the clock selector or to peripherals.
// (RULE_04) crystal plain or divide-by-two mode; divide-by-two gives 50% duty.
// (RULE_05) crystal frequency code chosen by crystal range, 000 to 111.
// (RULE_06) RC and C frequency code chosen by range, 000 to 111.
// (RULE_07) valid flag shows stabilised oscillator; software waits for it before selecting.
// (RULE_08) crystal start: both pins analog, enable, poll valid, then select.
// (RULE_09) RC start like crystal with pin two only; pin one untouched.
// (RULE_10) capacitor mode starts like RC mode, pin two analog only.
// (RULE_11) CMOS clock enters on pin two as digital input; pin one unused.
// (RULE_12) valid flag reads zero in CMOS clock mode.
// (RULE_13) select 000 precision, 001 external, 010 reserved, 011 rtc, 1xx low-power.
// (RULE_14) switchover completes after one period of the slower of both oscillators.
// (RULE_15) external valid indication synchronised before it is readable.
module oscsrc_ctrl #(
  parameter int VALID_EDGE_COUNT = oscsrc_pkg::VALID_EDGES
) (
  input wire logic clk, // 20 MHz bus clock
  input wire logic reset_n, // asynchronous reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high for write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error for unmapped address
  input wire logic ext_osc_raw, // oscillator seen at pin two, asynchronous
  input wire logic rtc_osc_raw, // rtc oscillator, asynchronous
  output logic [2:0] ext_osc_freq_range, // bias code to the drive circuit
  output logic [2:0] ext_osc_mode, // drive circuit mode
  output oscsrc_pkg::oscsrc_pwr_s pwr, // oscillator enables and pin setup
  output logic [2:0] sys_src_active, // source code the selector now uses
  output logic sys_ext_clk, // external clock towards the system selector
  output logic periph_ext_clk // external clock towards timers and counter array
);
  // the edge counter is eight bits wide, and a single edge proves no stable oscillation
  if (VALID_EDGE_COUNT < 2 || VALID_EDGE_COUNT > 255) begin : g_bad_count
    $error("VALID_EDGE_COUNT out of range");
  end

  typedef struct packed {
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic rtc_s1;
    logic rtc_s2;
    logic rtc_s3;
    oscsrc_pkg::oscsrc_cfg_s cfg;
    logic [2:0] select;
    logic [2:0] active;
    logic busy;
    logic seen_old;
    logic seen_new;
    logic [7:0] edge_cnt;
    logic valid;
    logic div_tog;
    logic ext_clk;
    logic periph_clk;
    oscsrc_pkg::oscsrc_pwr_s pwr;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } oscsrc_state_s;

  oscsrc_state_s st_r;
  oscsrc_state_s st_nxt;

  // one tick per period of the source; the internal ones run faster than the bus clock
  function automatic logic src_tick(input logic [2:0] sel, input logic ext_rise,
                                    input logic rtc_rise);
    logic t;
    t = 1'b1;
    if (sel[2] == 1'b0) begin
      unique case (oscsrc_pkg::oscsrc_src_e'(sel[1:0]))
        oscsrc_pkg::OSCSRC_SRC_PREC: t = 1'b1;
        oscsrc_pkg::OSCSRC_SRC_EXT: t = ext_rise;
        oscsrc_pkg::OSCSRC_SRC_RSVD: t = 1'b1;
        oscsrc_pkg::OSCSRC_SRC_RTC: t = rtc_rise;
      endcase
    end
    return t;
  endfunction

  logic ext_rise;
  logic rtc_rise;
  logic mode_cmos;
  logic mode_div2;
  logic mode_two_only;
  logic [31:0] ctrl_rd;
  logic [31:0] stat_rd;
  logic hit_ctrl;
  logic hit_sel;
  logic hit_stat;
  logic wr_done;
  logic ext_src;

  // edges are taken from the second and third stage, never the first
  assign ext_rise = st_r.ext_s2 & ~st_r.ext_s3; // RULE_15
  assign rtc_rise = st_r.rtc_s2 & ~st_r.rtc_s3;
  assign mode_cmos = st_r.cfg.mode[2:1] == 2'b01;
  assign mode_div2 = st_r.cfg.mode[1] & st_r.cfg.mode[0]; // cmos/2 and crystal/2
  assign mode_two_only = st_r.cfg.mode == oscsrc_pkg::OSCSRC_MODE_RC
    || st_r.cfg.mode == oscsrc_pkg::OSCSRC_MODE_CAP;
  assign hit_ctrl = paddr == oscsrc_pkg::EXT_OSC_CONTROL_OFS;
  assign hit_sel = paddr == oscsrc_pkg::CLOCK_SELECT_OFS;
  assign hit_stat = paddr == oscsrc_pkg::STATUS_OFS;
  assign wr_done = psel & penable & st_r.pready & pwrite;
  // pin two as seen, or halved so that both halves last one source period
  assign ext_src = (st_r.cfg.mode == oscsrc_pkg::OSCSRC_MODE_OFF) ? 1'b0 :
    mode_div2 ? st_r.div_tog : st_r.ext_s3; // RULE_04

  // register read images
  always_comb begin
    ctrl_rd = '0;
    ctrl_rd[oscsrc_pkg::FREQ_RANGE_LSB +: 3] = st_r.cfg.freq_range;
    ctrl_rd[oscsrc_pkg::MODE_LSB +: 3] = st_r.cfg.mode;
    ctrl_rd[oscsrc_pkg::VALID_FLAG_BIT] = st_r.valid & ~mode_cmos; // RULE_12
    ctrl_rd[oscsrc_pkg::PERIPH_ROUTE_BIT] = st_r.cfg.periph_route;
    stat_rd = '0;
    stat_rd[oscsrc_pkg::ACTIVE_SRC_LSB +: 3] = st_r.active;
    stat_rd[oscsrc_pkg::SWITCH_BUSY_BIT] = st_r.busy;
    stat_rd[oscsrc_pkg::LP_OSC_ON_BIT] = st_r.pwr.lp_osc_enable;
  end

  // next state of the whole block
  always_comb begin
    st_nxt = st_r;
    // two flip-flops before any logic looks at the pins
    st_nxt.ext_s1 = ext_osc_raw;
    st_nxt.ext_s2 = st_r.ext_s1;
    st_nxt.ext_s3 = st_r.ext_s2;
    st_nxt.rtc_s1 = rtc_osc_raw;
    st_nxt.rtc_s2 = st_r.rtc_s1;
    st_nxt.rtc_s3 = st_r.rtc_s2;

    // apb: one wait state, answer raised in the access phase
    st_nxt.pready = 1'b0;
    st_nxt.pslverr = 1'b0;
    if (psel & penable & ~st_r.pready) begin
      st_nxt.pready = 1'b1;
      st_nxt.pslverr = ~(hit_ctrl | hit_sel | hit_stat);
      st_nxt.prdata = '0;
      if (!pwrite) begin
        st_nxt.prdata = hit_ctrl ? ctrl_rd : hit_sel ? {29'h0, st_r.select} :
          hit_stat ? stat_rd : 32'h0;
      end
    end

    // software writes take effect at the completing edge
    if (wr_done & hit_ctrl) begin
      st_nxt.cfg.freq_range = pwdata[oscsrc_pkg::FREQ_RANGE_LSB +: 3]; // RULE_05 RULE_06
      st_nxt.cfg.mode = pwdata[oscsrc_pkg::MODE_LSB +: 3]; // RULE_04
      st_nxt.cfg.periph_route = pwdata[oscsrc_pkg::PERIPH_ROUTE_BIT]; // RULE_03
      if (pwdata[oscsrc_pkg::MODE_LSB +: 3] != st_r.cfg.mode) begin
        st_nxt.valid = 1'b0;
        st_nxt.edge_cnt = '0;
      end
    end
    if (wr_done & hit_sel) begin
      st_nxt.select = pwdata[oscsrc_pkg::SELECT_LSB +: 3];
    end

    // valid detector: counts synchronised edges while the drive runs
    if (st_r.cfg.mode == oscsrc_pkg::OSCSRC_MODE_OFF) begin
      st_nxt.valid = 1'b0;
      st_nxt.edge_cnt = '0;
    end else if (ext_rise && !st_r.valid && st_nxt.edge_cnt == st_r.edge_cnt) begin
      st_nxt.edge_cnt = st_r.edge_cnt + 8'h01;
      if (st_r.edge_cnt == 8'(VALID_EDGE_COUNT - 1)) begin
        st_nxt.valid = 1'b1; // RULE_07
      end
    end

    // divide-by-two toggles on every rising edge, so both halves last one period
    if (ext_rise) begin
      st_nxt.div_tog = ~st_r.div_tog; // RULE_04
    end
    // either the selector or the peripherals get the clock, never both
    st_nxt.ext_clk = ext_src & ~st_r.cfg.periph_route; // RULE_03
    st_nxt.periph_clk = ext_src & st_r.cfg.periph_route; // RULE_03

    // on-the-fly switch: wait for a period of both old and new source
    if (st_r.select != st_r.active && !st_r.busy) begin
      st_nxt.busy = 1'b1;
      st_nxt.seen_old = 1'b0;
      st_nxt.seen_new = 1'b0;
    end else if (st_r.busy) begin
      st_nxt.seen_old = st_r.seen_old | src_tick(st_r.active, ext_rise, rtc_rise);
      st_nxt.seen_new = st_r.seen_new | src_tick(st_r.select, ext_rise, rtc_rise);
      if (st_nxt.seen_old & st_nxt.seen_new) begin
        st_nxt.active = st_r.select; // RULE_14 RULE_13
        st_nxt.busy = 1'b0;
      end
    end

    // the low-power oscillator must already run while it is the target of a switch
    st_nxt.pwr.lp_osc_enable = st_nxt.active[2] | st_nxt.select[2]; // RULE_02 RULE_13
    st_nxt.pwr.ext_osc_enable = st_r.cfg.mode != oscsrc_pkg::OSCSRC_MODE_OFF;
    st_nxt.pwr.pin_one_analog = st_r.cfg.mode[2:1] == 2'b11; // RULE_08
    // rc and capacitor leave pin one alone; cmos drops it entirely
    st_nxt.pwr.pin_two_analog = mode_two_only | st_nxt.pwr.pin_one_analog; // RULE_09 RULE_10
    st_nxt.pwr.pin_two_digital_in = mode_cmos; // RULE_11
  end

  // the whole state in one register; reset loads constants only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
      st_r.select <= oscsrc_pkg::SELECT_RST; // RULE_01
      st_r.active <= oscsrc_pkg::SELECT_RST; // RULE_01
      st_r.cfg.freq_range <= oscsrc_pkg::FREQ_RANGE_RST;
      st_r.pwr.lp_osc_enable <= 1'b1; // RULE_02
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign ext_osc_freq_range = st_r.cfg.freq_range;
  assign ext_osc_mode = st_r.cfg.mode;
  assign pwr = st_r.pwr;
  assign sys_src_active = st_r.active;
  assign sys_ext_clk = st_r.ext_clk;
  assign periph_ext_clk = st_r.periph_clk;
endmodule // oscsrc_ctrl

// ==== testbench/oscsrc_ctrl_monitor.sv ====
// checker: port-level assertions for the oscillator source control
module oscsrc_ctrl_monitor #(
  parameter int VALID_EDGE_COUNT = 16
) (
  input wire logic clk, // bus clock
  input wire logic reset_n, // async reset
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb address
  input wire logic [31:0] pwdata, // write data
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic [2:0] ext_osc_freq_range, // bias code
  input wire logic [2:0] ext_osc_mode, // drive mode
  input wire oscsrc_pkg::oscsrc_pwr_s pwr, // enables
  input wire logic [2:0] sys_src_active, // source in use
  input wire logic sys_ext_clk, // clock to selector
  input wire logic periph_ext_clk // clock to peripherals
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // a write lands before the registered copies are compared, two edges on
  a_reset_lp_sel: assert property ($rose(reset_n)
    |-> sys_src_active == 3'h4 && pwr.lp_osc_enable)
    else $error("low-power source not selected after reset");
  a_lp_on_sel: assert property (sys_src_active[2] |-> pwr.lp_osc_enable)
    else $error("low-power oscillator off while selected");
  a_route_excl: assert property (!(sys_ext_clk && periph_ext_clk))
    else $error("external clock on both routes");
  a_cfg_copy: assert property (pready && pwrite && paddr == 8'h00 |-> ##2
    {ext_osc_mode, ext_osc_freq_range} == {$past(pwdata[6:4], 2), $past(pwdata[2:0], 2)})
    else $error("mode or frequency code not applied");
  a_xtal_pins: assert property (ext_osc_mode[2:1] == 2'b11 && $past(ext_osc_mode[2:1]) == 2'b11
    |-> pwr.pin_one_analog && pwr.pin_two_analog)
    else $error("crystal pin setup wrong");
  a_rc_pins: assert property (ext_osc_mode[2:1] == 2'b10 && $past(ext_osc_mode[2:1]) == 2'b10
    |-> !pwr.pin_one_analog && pwr.pin_two_analog)
    else $error("rc or capacitor pin setup wrong");
  a_cmos_pins: assert property (ext_osc_mode[2:1] == 2'b01 && $past(ext_osc_mode[2:1]) == 2'b01
    |-> !pwr.pin_one_analog && pwr.pin_two_digital_in)
    else $error("cmos pin setup wrong");
  a_cmos_no_valid: assert property (pready && !pwrite && paddr == 8'h00
    && ext_osc_mode[2:1] == 2'b01 && $past(ext_osc_mode[2:1]) == 2'b01 |-> !prdata[7])
    else $error("valid flag set in cmos mode");
  a_one_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready ##1 !pready)
    else $error("ready not after one wait state");
  a_unmapped_err: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08}))
    else $error("error response wrong for address");
endmodule // oscsrc_ctrl_monitor

bind oscsrc_ctrl oscsrc_ctrl_monitor #(.VALID_EDGE_COUNT(VALID_EDGE_COUNT)) i_mon (.clk(clk),
  .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ext_osc_freq_range(ext_osc_freq_range), .ext_osc_mode(ext_osc_mode), .pwr(pwr),
  .sys_src_active(sys_src_active), .sys_ext_clk(sys_ext_clk), .periph_ext_clk(periph_ext_clk));

// ==== testbench/oscsrc_osc_model.sv ====
// partner: external oscillator network seen at pin two
module oscsrc_osc_model #(
  parameter int HALF = 150
) (
  input wire logic en, // drive circuit enabled
  input wire logic slow, // four times longer period
  output logic osc // level at pin two
);
  timeunit 1ns;
  timeprecision 1ns;
  initial osc = 1'b0;
  // oscillates only while the drive circuit is powered; pin one is never used
  always begin
    #(slow ? HALF * 4 : HALF);
    osc = en ? ~osc : 1'b0;
  end
endmodule // oscsrc_osc_model

// ==== testbench/oscillator_source_control_test.sv ====
// testbench: apb sequences with expected values for the oscillator source control
module oscillator_source_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic rtc = 1'b0, slow = 1'b0, ext_osc, pready, pslverr, sys_ext_clk, periph_ext_clk;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [2:0] freq, mode, active;
  oscsrc_pkg::oscsrc_pwr_s pwr;
  int err_total = 0, compares = 0;
  always #25 clk = ~clk;
  always #777 rtc = ~rtc;
  oscsrc_ctrl #(.VALID_EDGE_COUNT(3)) i_dut (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_osc_raw(ext_osc), .rtc_osc_raw(rtc),
    .ext_osc_freq_range(freq), .ext_osc_mode(mode), .pwr(pwr), .sys_src_active(active),
    .sys_ext_clk(sys_ext_clk), .periph_ext_clk(periph_ext_clk));
  // partner half period in bench clocks: 150 ns over the 50 ns clock
  localparam int HALF_CLKS = 3;
  oscsrc_osc_model #(.HALF(HALF_CLKS * 50)) i_osc (.en(pwr.ext_osc_enable), .slow(slow),
    .osc(ext_osc));
  task automatic give_verdict();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // request held until ready is sampled high at a rising edge; data taken and released there
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      chk("pready", 32'h1, 32'h0);
      give_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q; logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q; logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(nm, exp, q);
  endtask
  // bounded polling: a source that never settles ends the run
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    logic [31:0] q; logic e; int n;
    n = 0;
    do begin apb(1'b0, a, 32'h0, q, e); n++; end while ((q & m) !== v && n < 200);
    chk("poll", v, q & m);
    if ((q & m) !== v) give_verdict();
  endtask
  // one high and one low phase of a clock output; the other output must stay low meanwhile
  task automatic phase_chk(input string nm, input logic per, input int exp_len);
    logic c;
    int n;
    int ph;
    int hi;
    int lo;
    int oth;
    n = 0;
    ph = 0;
    hi = 0;
    lo = 0;
    oth = 0;
    // let a mode change settle so that no shortened phase is measured
    repeat (20) @(posedge clk);
    while (ph < 4 && n < 100) begin
      @(posedge clk);
      n++;
      c = per ? periph_ext_clk : sys_ext_clk;
      if ((per ? sys_ext_clk : periph_ext_clk) !== 1'b0) oth++;
      if (ph == 0 && c === 1'b0) ph = 1;
      else if (ph == 1 && c === 1'b1) ph = 2;
      else if (ph == 2 && c === 1'b0) ph = 3;
      else if (ph == 3 && c === 1'b1) ph = 4;
      if (ph == 2) hi++;
      if (ph == 3) lo++;
    end
    chk({nm, " high"}, exp_len, hi);
    chk({nm, " low"}, exp_len, lo);
    chk({nm, " other route"}, 32'h0, oth);
  endtask
  initial begin
    logic [31:0] q; logic e;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    rd("status", 8'h08, 32'h24);
    rd("select", 8'h04, 32'h4);
    apb(1'b0, 8'h0c, 32'h0, q, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    wr(8'h04, 32'h0);
    poll(8'h08, 32'h37, 32'h00);
    wr(8'h04, 32'h3);
    poll(8'h08, 32'h37, 32'h03);
    wr(8'h04, 32'h5);
    poll(8'h08, 32'h34, 32'h24);
    wr(8'h00, 32'h67);
    poll(8'h00, 32'h80, 32'h80);
    chk("xtal pwr", 32'h1e, {27'h0, pwr});
    chk("xtal mode", 32'h6, {29'h0, mode});
    wr(8'h04, 32'h1);
    poll(8'h08, 32'h37, 32'h01);
    chk("ext active", 32'h1, {29'h0, active});
    wr(8'h04, 32'h4);
    poll(8'h08, 32'h37, 32'h24);
    phase_chk("xtal sys", 1'b0, HALF_CLKS);
    wr(8'h00, 32'h177);
    phase_chk("xtal div2 periph", 1'b1, 2 * HALF_CLKS);
    wr(8'h00, 32'h20);
    repeat (60) @(posedge clk);
    rd("cmos ctrl", 8'h00, 32'h20);
    chk("cmos pwr", 32'h19, {27'h0, pwr});
    wr(8'h00, 32'h30);
    phase_chk("cmos div2 sys", 1'b0, 2 * HALF_CLKS);
    slow <= 1'b1;
    wr(8'h00, 32'h42);
    poll(8'h00, 32'h80, 32'h80);
    chk("rc range", 32'h2, {29'h0, freq});
    chk("rc pwr", 32'h1a, {27'h0, pwr});
    wr(8'h00, 32'h151);
    wr(8'h0c, 32'h0);
    rd("cap ctrl", 8'h00, 32'h151);
    // a second reset in mid-run must bring back the low-power source
    wr(8'h04, 32'h0);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd("reset select", 8'h04, 32'h4);
    rd("reset status", 8'h08, 32'h24);
    rd("reset ctrl", 8'h00, 32'h0);
    give_verdict();
  end
endmodule // oscillator_source_control_test
